// [inc/gain_trim_defs.svh]
// Register offsets, field positions, reset values and link timing for the gain trim block
`ifndef GAIN_TRIM_DEFS_SVH
`define GAIN_TRIM_DEFS_SVH

// Avalon byte offsets (word aligned)
`define GT_OFS_TRIM_A 4'h0
`define GT_OFS_TRIM_B 4'h4
`define GT_OFS_RESULTS 4'h8
`define GT_OFS_STATUS 4'hC

// Trim register layout: sign flag above a six-bit magnitude
`define GT_TRIM_W 7
`define GT_TRIM_SIGN 6
`define GT_MAG_W 6
`define GT_TRIM_RESET 7'h00

// Result layout
`define GT_RES_W 12
`define GT_RES_B_LSB 16
`define GT_GAIN_SHIFT 12
`define GT_ROUND_HALF 19'sh00800
`define GT_RES_MAX 13'sh07FF
`define GT_RES_MIN 13'sh1800

// Status bits
`define GT_ST_FRAME 0
`define GT_ST_CLAMP_A 1
`define GT_ST_CLAMP_B 2

// Falling serial clock edge numbers within a frame
`define GT_EDGE_OWN_FIRST 6'h13
`define GT_EDGE_OWN_LAST 6'h1E
`define GT_EDGE_OTHER_FIRST 6'h21
`define GT_EDGE_OTHER_LAST 6'h2C
`define GT_EDGE_RELEASE 6'h2F
`define GT_EDGE_MAX 6'h3F

`endif

// [inc/gain_trim_pkg.sv]
// Types shared by the gain trim block
package gain_trim_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

  typedef logic signed [11:0] result_t;
  typedef logic [6:0] trim_t;

endpackage

// [logic/dual_channel_gain_trim.sv]
// Dual channel gain trim with register slave and framed serial result port
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "gain_trim_defs.svh"

// Behaviour
// RULE1: Separate trim register per converter channel
// RULE2: Trim is sign flag plus six-bit magnitude
// RULE3: Result scaled by one plus/minus magnitude/4096
// RULE4: Sign clear subtracts magnitude term
// RULE5: Sign set adds magnitude term
// RULE6: Zero magnitude gives exactly unity gain
// RULE7: Step one part in 4096, range ~1.5%
// RULE8: Host calibrates from zero-gain sensor code
// RULE9: Host should measure both full-scale codes
// RULE10: Host samples data on falling serial clock
// RULE11: Host drives active low frame per word
// RULE12: Host treats frame sync as active low
// RULE13: Host takes 31-bit MSB-first zero-filled words
// RULE14: Host captures both outputs together
// RULE15: Result ends valid on 31st falling edge
// RULE16: Outputs go high impedance when select rises
// RULE17: Clamp scaled result at full scale
module dual_channel_gain_trim (
  input wire logic clk, // System clock, 200 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [3:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon stall
  input wire logic raw_valid, // Raw results strobe from converter core
  input wire logic [11:0] raw_result_a, // Raw channel A result, two's complement
  input wire logic [11:0] raw_result_b, // Raw channel B result, two's complement
  output logic corrected_valid, // Corrected results strobe
  output logic [11:0] corrected_result_a, // Corrected channel A result
  output logic [11:0] corrected_result_b, // Corrected channel B result
  input wire logic sclk, // Serial clock from host
  input wire logic cs_n, // Frame select from host, active low
  output logic serial_out_first, // Serial data, channel A first
  output logic serial_out_first_oe_n, // Output enable, low while driven
  output logic serial_out_second, // Serial data, channel B first
  output logic serial_out_second_oe_n // Output enable, low while driven
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access completes

  gain_trim_pkg::bus_state_t bus_q;
  gain_trim_pkg::bus_state_t bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic status_frame;
  logic [1:0] clamp_flags;
  logic [11:0] res_a_view;
  logic [11:0] res_b_view;
  logic [6:0] trim_a_view;
  logic [6:0] trim_b_view;

  wire bus_req = avs_read | avs_write;
  wire bus_done = (bus_q == gain_trim_pkg::BUS_DONE);
  wire wr_fire = avs_write & bus_done;
  wire sel_trim_a = (avs_address == `GT_OFS_TRIM_A);
  wire sel_trim_b = (avs_address == `GT_OFS_TRIM_B);
  wire sel_results = (avs_address == `GT_OFS_RESULTS);
  wire sel_status = (avs_address == `GT_OFS_STATUS);
  wire [1:0] trim_wr = {wr_fire & sel_trim_b, wr_fire & sel_trim_a}; // [RULE1]

  assign avs_waitrequest = bus_req & ~bus_done;
  assign avs_readdata = rdata_q;

  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      gain_trim_pkg::BUS_IDLE: begin
        if (bus_req) begin
          bus_d = gain_trim_pkg::BUS_DONE;
        end
      end
      gain_trim_pkg::BUS_DONE: begin
        bus_d = gain_trim_pkg::BUS_IDLE;
      end
      default: begin
        bus_d = gain_trim_pkg::BUS_IDLE;
      end
    endcase
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel_trim_a) begin
      rdata_d[`GT_TRIM_W-1:0] = trim_a_view;
    end else if (sel_trim_b) begin
      rdata_d[`GT_TRIM_W-1:0] = trim_b_view;
    end else if (sel_results) begin
      rdata_d[`GT_RES_W-1:0] = res_a_view;
      rdata_d[`GT_RES_B_LSB +: `GT_RES_W] = res_b_view;
    end else if (sel_status) begin
      rdata_d[`GT_ST_FRAME] = status_frame;
      rdata_d[`GT_ST_CLAMP_A] = clamp_flags[0];
      rdata_d[`GT_ST_CLAMP_B] = clamp_flags[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_q <= gain_trim_pkg::BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      if (avs_read && !bus_done) begin
        rdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame select seen from the system clock

  logic cs_meta_q;
  logic cs_sync_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
    end
  end

  assign status_frame = ~cs_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gain correction datapath, one copy per channel

  logic valid_p1_q;
  logic valid_p2_q;
  logic [11:0] raw_in [2];
  logic [11:0] hold_word [2];

  assign raw_in[0] = raw_result_a;
  assign raw_in[1] = raw_result_b;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      valid_p1_q <= 1'b0;
      valid_p2_q <= 1'b0;
    end else begin
      valid_p1_q <= raw_valid;
      valid_p2_q <= valid_p1_q;
    end
  end

  assign corrected_valid = valid_p2_q;

  for (genvar c = 0; c < 2; c++) begin : ch
    gain_trim_pkg::trim_t trim_q;
    gain_trim_pkg::result_t raw_q;
    logic signed [18:0] prod_q;
    logic [11:0] corr_q;
    logic clamp_q;
    logic [11:0] hold_q;

    wire [`GT_MAG_W-1:0] mag = trim_q[`GT_MAG_W-1:0]; // [RULE2]
    wire sign_up = trim_q[`GT_TRIM_SIGN]; // [RULE2]
    wire signed [6:0] mag_s = $signed({1'b0, mag});
    wire signed [18:0] prod_d = $signed(raw_in[c]) * mag_s; // [RULE3]
    // Rounded product over 4096; zero magnitude yields exactly zero
    wire signed [18:0] prod_rnd = prod_q + `GT_ROUND_HALF; // [RULE7] [RULE6]
    wire signed [6:0] term = prod_rnd[18:`GT_GAIN_SHIFT]; // [RULE3]
    wire signed [12:0] raw_ext = {raw_q[11], raw_q};
    wire signed [12:0] term_ext = {{6{term[6]}}, term};
    wire signed [12:0] sum_up = raw_ext + term_ext; // [RULE5]
    wire signed [12:0] sum_dn = raw_ext - term_ext; // [RULE4]
    wire signed [12:0] sum = sign_up ? sum_up : sum_dn;
    wire over = (sum > `GT_RES_MAX);
    wire under = (sum < `GT_RES_MIN);
    wire [11:0] corr_d = over ? 12'h7FF : (under ? 12'h800 : sum[11:0]); // [RULE17]

    always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        trim_q <= `GT_TRIM_RESET;
      end else if (trim_wr[c]) begin
        trim_q <= avs_writedata[`GT_TRIM_W-1:0]; // [RULE1] [RULE6]
      end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        raw_q <= 12'sh000;
        prod_q <= 19'sh00000;
      end else if (raw_valid) begin
        raw_q <= raw_in[c];
        prod_q <= prod_d;
      end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        corr_q <= 12'h000;
        clamp_q <= 1'b0;
      end else if (valid_p1_q) begin
        corr_q <= corr_d;
        clamp_q <= over | under; // [RULE17]
      end
    end

    // Word handed to the link only changes while no frame is running
    always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        hold_q <= 12'h000;
      end else if (cs_sync_q) begin
        hold_q <= corr_q;
      end
    end

    assign hold_word[c] = hold_q;
    assign clamp_flags[c] = clamp_q;
  end

  assign corrected_result_a = ch[0].corr_q;
  assign corrected_result_b = ch[1].corr_q;
  assign res_a_view = ch[0].corr_q;
  assign res_b_view = ch[1].corr_q;
  assign trim_a_view = ch[0].trim_q;
  assign trim_b_view = ch[1].trim_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial link, clocked by the host's serial clock falling edge

  logic [5:0] edge_cnt_q;
  logic released_q;
  logic [11:0] shadow_q [2];

  // Frame select high holds the link in reset; the edge coinciding with
  // its fall is therefore not counted
  wire [5:0] edge_num = (edge_cnt_q == `GT_EDGE_MAX) ? edge_cnt_q : edge_cnt_q + 6'h01;
  wire in_own = (edge_num >= `GT_EDGE_OWN_FIRST) && (edge_num <= `GT_EDGE_OWN_LAST);
  wire in_other = (edge_num >= `GT_EDGE_OTHER_FIRST) && (edge_num <= `GT_EDGE_OTHER_LAST);
  wire [3:0] own_idx = 4'(`GT_EDGE_OWN_LAST - edge_num);
  wire [3:0] other_idx = 4'(`GT_EDGE_OTHER_LAST - edge_num);

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_q <= 6'h00;
      released_q <= 1'b0;
    end else begin
      edge_cnt_q <= edge_num;
      if (edge_num == `GT_EDGE_RELEASE) begin
        released_q <= 1'b1;
      end
    end
  end

  for (genvar l = 0; l < 2; l++) begin : lane
    logic bit_q;

    // Hold words are quiet while select is low, so the snapshot is stable
    always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
        shadow_q[l] <= 12'h000;
      end else if (edge_cnt_q == 6'h00) begin
        shadow_q[l] <= hold_word[l];
      end
    end

    // MSB driven after edge 19, LSB after edge 30, read on edge 31
    always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
        bit_q <= 1'b0;
      end else if (in_own) begin
        bit_q <= shadow_q[l][own_idx]; // [RULE15]
      end else if (in_other) begin
        bit_q <= shadow_q[1-l][other_idx];
      end else begin
        bit_q <= 1'b0;
      end
    end
  end

  assign serial_out_first = lane[0].bit_q;
  assign serial_out_second = lane[1].bit_q;
  assign serial_out_first_oe_n = cs_n | released_q; // [RULE16]
  assign serial_out_second_oe_n = cs_n | released_q; // [RULE16]

endmodule
`default_nettype wire

// [verification/gain_trim_props.sv]
// Port checks for the gain trim block
`timescale 1ns/1ps
`default_nettype none
module gain_trim_props (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic raw_valid, // Raw strobe
  input wire logic corrected_valid, // Out strobe
  input wire logic [11:0] corrected_result_a, // Out A
  input wire logic [11:0] corrected_result_b, // Out B
  input wire logic sclk, // Link clock
  input wire logic cs_n, // Frame select
  input wire logic serial_out_first, // Line one
  input wire logic serial_out_first_oe_n, // Enable one
  input wire logic serial_out_second_oe_n // Enable two
);
  logic [5:0] edge_q;
  // Falling edges seen in the current frame
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_q <= 6'h00;
    end else if (edge_q != 6'h3F) begin
      edge_q <= edge_q + 6'h01;
    end
  end
  sequence stall_s; avs_waitrequest; endsequence
  sequence done_s; !avs_waitrequest; endsequence
  write_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(avs_write) |-> stall_s ##1 done_s) else $error("write wait wrong");
  read_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    $changed(avs_readdata) |-> avs_read && !avs_waitrequest) else $error("read data moved");
  valid_delay_a: assert property (@(posedge clk) disable iff (!nrst)
    raw_valid |-> ##2 corrected_valid) else $error("result strobe late");
  valid_cause_a: assert property (@(posedge clk) disable iff (!nrst)
    corrected_valid |-> $past(raw_valid, 2)) else $error("stray result strobe");
  result_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !corrected_valid |-> $stable(corrected_result_a) && $stable(corrected_result_b))
    else $error("result moved");
  frame_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(cs_n) |-> !serial_out_first_oe_n && !serial_out_second_oe_n) else $error("no drive");
  select_release_a: assert property (@(posedge clk) disable iff (!nrst)
    cs_n |-> serial_out_first_oe_n && serial_out_second_oe_n) else $error("driven idle");
  lead_zero_a: assert property (@(negedge sclk) disable iff (cs_n)
    edge_q inside {[6'h01:6'h12], [6'h1F:6'h20]} |-> !serial_out_first) else $error("bad pad");
  tail_release_a: assert property (@(negedge sclk) disable iff (cs_n)
    edge_q == 6'h2F |-> serial_out_first_oe_n && serial_out_second_oe_n) else $error("late");
endmodule
`default_nettype wire

// [verification/host_serial_model.sv]
// Host serial port: frame clock, active low select, two receive lines
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  input wire logic go, // Start a frame
  input wire logic data_first, // Line one
  input wire logic oe_first_n, // Enable one
  input wire logic data_second, // Line two
  input wire logic oe_second_n, // Enable two
  output logic sclk, // Link clock
  output logic cs_n, // Frame select
  output logic [47:0] word_first, // Line one word
  output logic [47:0] word_second, // Line two word
  output logic done // Frame over
);
  logic last_f = 1'b0;
  logic last_s = 1'b0;
  wire logic line_f;
  wire logic line_s;
  // A released line shows the inverse of its last driven level
  assign line_f = oe_first_n ? ~last_f : data_first;
  assign line_s = oe_second_n ? ~last_s : data_second;
  always @(posedge sclk) begin
    if (!oe_first_n) last_f <= data_first;
    if (!oe_second_n) last_s <= data_second;
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      word_first <= {word_first[46:0], line_f};
      word_second <= {word_second[46:0], line_s};
    end
  end
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    done = 1'b0;
    forever begin
      @(posedge go);
      done = 1'b0;
      #3 cs_n = 1'b0;
      repeat (48) begin
        #6 sclk = 1'b1;
        #6 sclk = 1'b0;
      end
      #6 cs_n = 1'b1;
      done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the gain trim block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic raw_valid = 1'b0;
  logic [11:0] raw_result_a = 12'h000;
  logic [11:0] raw_result_b = 12'h000;
  logic corrected_valid;
  logic [11:0] corrected_result_a;
  logic [11:0] corrected_result_b;
  logic sclk, cs_n, d_f, oe_f_n, d_s, oe_s_n, done;
  logic go = 1'b0;
  logic [47:0] w_f, w_s;
  int bad_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  dual_channel_gain_trim dut_u (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid),
    .raw_result_a(raw_result_a), .raw_result_b(raw_result_b),
    .corrected_valid(corrected_valid), .corrected_result_a(corrected_result_a),
    .corrected_result_b(corrected_result_b), .sclk(sclk), .cs_n(cs_n),
    .serial_out_first(d_f), .serial_out_first_oe_n(oe_f_n),
    .serial_out_second(d_s), .serial_out_second_oe_n(oe_s_n));
  host_serial_model host_u (.go(go), .data_first(d_f), .oe_first_n(oe_f_n),
    .data_second(d_s), .oe_second_n(oe_s_n), .sclk(sclk), .cs_n(cs_n),
    .word_first(w_f), .word_second(w_s), .done(done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    logic [31:0] d;
    bus(0, 4'h0, 32'h0, d); check("trim a reset", 32'h0, d);
    bus(0, 4'h4, 32'h0, d); check("trim b reset", 32'h0, d);
    bus(1, 4'h0, 32'hFFFFFFFF, d);
    bus(1, 4'h4, 32'h00000040, d);
    bus(0, 4'h0, 32'h0, d); check("trim a", 32'h7F, d);
    bus(0, 4'h4, 32'h0, d); check("trim b", 32'h40, d);
    bus(0, 4'h2, 32'h0, d); check("unmapped", 32'h0, d);
  endtask
  task automatic pulse_raw(input logic [11:0] ra, input logic [11:0] rb);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_result_a <= ra;
    raw_result_b <= rb;
    @(posedge clk);
    raw_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic s_calib();
    logic [31:0] d;
    logic [31:0] pos;
    logic [31:0] neg;
    int span;
    int mag;
    logic [6:0] trim;
    bus(1, 4'h0, 32'h0, d);
    bus(1, 4'h4, 32'h0, d);
    pulse_raw(12'h7E0, 12'h7E0);
    bus(0, 4'h8, 32'h0, pos);
    pulse_raw(12'h820, 12'h820);
    bus(0, 4'h8, 32'h0, neg);
    check("cleared gain", 32'h07E00820, {pos[15:0], neg[15:0]});
    // Host trim from measured span against the ideal full-scale span
    span = int'($signed(pos[11:0])) - int'($signed(neg[11:0]));
    mag = (4094 - span) * 4096 / span;
    trim = (mag < 0) ? {1'b0, 6'(-mag)} : {1'b1, 6'(mag)};
    bus(1, 4'h0, {25'h0, trim}, d);
    bus(1, 4'h4, {25'h0, trim}, d);
    bus(0, 4'h4, 32'h0, d); check("derived trim", 32'h7E, d);
    pulse_raw(12'h7E0, 12'h7E0);
    check("cal top", 32'h007FF7FF, {8'h0, corrected_result_b, corrected_result_a});
    pulse_raw(12'h820, 12'h820);
    check("cal bottom", 32'h00801801, {8'h0, corrected_result_b, corrected_result_a});
  endtask
  task automatic gain_case(input logic [6:0] ta, input logic [6:0] tb_, input logic [11:0] raw,
                           input logic [11:0] ea, input logic [11:0] eb, input logic [1:0] ec);
    logic [31:0] d;
    bus(1, 4'h0, {25'h0, ta}, d);
    bus(1, 4'h4, {25'h0, tb_}, d);
    pulse_raw(raw, raw);
    check("valid", 32'h1, {31'h0, corrected_valid});
    check("result a", {20'h0, ea}, {20'h0, corrected_result_a});
    check("result b", {20'h0, eb}, {20'h0, corrected_result_b});
    bus(0, 4'hC, 32'h0, d); check("clamp flags", {29'h0, ec, 1'b0}, d);
  endtask
  task automatic s_link();
    logic [31:0] d;
    int n;
    bus(0, 4'h8, 32'h0, d); check("results", 32'h0BF80C10, d);
    repeat (4) @(posedge clk);
    go <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, 4'hC, 32'h0, d); check("frame flag", 32'h1, d);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 300);
    go <= 1'b0;
    if (n >= 300) begin
      bad_count++;
      give_verdict();
    end
    check("line one head", 32'h00000C10, {1'b0, w_f[47:17]});
    check("line one tail", 32'h00005FC1, {15'h0, w_f[16:0]});
    check("line two head", 32'h00000BF8, {1'b0, w_s[47:17]});
    check("line two tail", 32'h00006081, {15'h0, w_s[16:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs();
    s_calib();
    gain_case(7'h00, 7'h40, 12'h7FF, 12'h7FF, 12'h7FF, 2'h0);
    gain_case(7'h3F, 7'h7F, 12'h400, 12'h3F0, 12'h410, 2'h0);
    gain_case(7'h7F, 7'h20, 12'h7F0, 12'h7FF, 12'h7E0, 2'h1);
    gain_case(7'h3F, 7'h7F, 12'h800, 12'h81F, 12'h800, 2'h2);
    gain_case(7'h3F, 7'h60, 12'hC00, 12'hC10, 12'hBF8, 2'h0);
    s_link();
    give_verdict();
  end
endmodule
bind dual_channel_gain_trim gain_trim_props chk_u (.clk(clk), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .raw_valid(raw_valid), .corrected_valid(corrected_valid),
  .corrected_result_a(corrected_result_a), .corrected_result_b(corrected_result_b),
  .sclk(sclk), .cs_n(cs_n), .serial_out_first(serial_out_first),
  .serial_out_first_oe_n(serial_out_first_oe_n),
  .serial_out_second_oe_n(serial_out_second_oe_n));
`default_nettype wire
